// File: hdl/adc_sequencer_control.sv
// Sequencer for a 16-channel 10-bit converter core: modes, timing,
// calibration, overrun handling and channel injection.
// Assumes the core delivers its result on core_result_in from logic on
// ref_clk_in by the end of the convert phase.
//
// Contract
// - Pick one of 16 channels per conversion, produce 10-bit result.
// - Overrun signalling: pulse interrupt when a result lands over unread one.
// - Overrun protection: hold next conversion until previous result read.
// - Single mode: convert selected channel once, store, stop.
// - Continuous mode: keep converting same channel, update result each time.
// - Scan single: convert each selected channel once, store after each.
// - Scan continuous: cycle through selected channels repeatedly.
// - Wait-for-read in continuous mode: buffer new result, pause until read.
// - Continuous mode accepts one injected channel without mode change.
// - Injected result goes to injection result register only.
// - After injection the running continuous mode resumes untouched.
// - Conversion lasts 14 conversion clocks, 2 sample clocks, 4 phases.
// - Conversion clock 24 or 96 phases; sample clock 1, 2 or 4.
// - Conversion clock code 11 gives 48 phases; sample code 11 gives 8.
// - Run full calibration after every reset, at least 1.6 ms.
// - Busy flag set for whole post-reset calibration.
// - Conversions allowed during calibration, which lengthens by their time.
// - After each conversion run one four-conversion-clock calibration cycle.
// - Channel pins not converted stay readable as digital inputs.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_sequencer_control
    import adc_seq_pkg::*;
#(
    parameter int CAL_CYC = `ADC_CAL_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [1:0] mode_in,
    input wire logic [3:0] channel_in,
    input wire logic wait_for_read_enable_in,
    input wire logic overrun_protect_in,
    input wire logic [1:0] conversion_clock_select_in,
    input wire logic [1:0] sample_clock_select_in,
    input wire logic inject_req_in,
    input wire logic [3:0] inject_channel_in,
    input wire logic result_read_in,
    input wire logic [9:0] core_result_in,
    input wire logic [15:0] analog_pins_in,
    output logic [3:0] core_channel_out,
    output logic core_sample_out,
    output logic core_convert_out,
    output logic core_calibrate_out,
    output logic [9:0] result_value_field_out,
    output logic [3:0] result_channel_out,
    output logic [9:0] injection_result_reg_out,
    output logic converter_busy_flag_out,
    output logic conversion_active_out,
    output logic overrun_irq_out,
    output logic complete_req_out,
    output logic inject_done_out,
    output logic [15:0] digital_pins_out
);

    // ----------------------------------------
    // Base phase divider
    // ----------------------------------------
    localparam int TCL_CYC = `ADC_TCL_CYC;
    localparam int CAL_W = $clog2(CAL_CYC + 1);
    logic [7:0] div_q;
    logic tcl_tick;
    logic seq_start;

    assign tcl_tick = (div_q == 8'(TCL_CYC - 1));

    // Restart on a new sample so it gets its full length
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || tcl_tick || seq_start) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Phase lengths in base phases
    // ----------------------------------------
    logic [11:0] tcc_len;
    logic [11:0] smp_len;
    logic [11:0] conv_len;
    logic [11:0] calc_len;

    always_comb begin
        unique case (conversion_clock_select_in)
            2'h2: tcc_len = 12'(`ADC_CTC_10_TCL);
            2'h3: tcc_len = 12'(`ADC_CTC_11_TCL);
            default: tcc_len = 12'(`ADC_CTC_00_TCL);
        endcase
    end

    // Two sample clocks, each 1, 2, 4 or 8 conversion clocks
    assign smp_len = tcc_len <<
        ({1'b0, sample_clock_select_in} + 3'h1);
    assign conv_len = 12'(`ADC_CONV_TCC * tcc_len);
    assign calc_len = tcc_len << `ADC_CALC_TCC_SHIFT;

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    seq_state_t state_q, state_d;
    logic [11:0] tmr_q, tmr_d;
    logic run_q;
    logic [3:0] scan_q;
    logic inj_pend_q;
    logic inj_act_q;
    logic unread_q;
    logic buf_full_q;
    logic [9:0] buf_q;
    logic [3:0] buf_ch_q;
    logic phase_end;
    logic is_cont;
    logic can_start;
    logic xfer_go;
    logic last_conv;

    assign phase_end = tcl_tick && (tmr_q == 12'h000);
    assign is_cont = (mode_in == MODE_CONT) || (mode_in == MODE_SCAN_CONT);
    assign can_start = run_q && !(overrun_protect_in && unread_q);
    assign seq_start = (state_q == ST_IDLE) && can_start;
    assign xfer_go = (state_q == ST_CONVERT) && phase_end;
    assign last_conv = (mode_in == MODE_SINGLE) ||
        ((mode_in == MODE_SCAN) && (scan_q == 4'h0));

    always_comb begin
        state_d = state_q;
        tmr_d = tmr_q;
        if (tcl_tick && (tmr_q != 12'h000)) begin
            tmr_d = tmr_q - 12'h001;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (can_start) begin
                    state_d = ST_SAMPLE;
                    tmr_d = smp_len - 12'h001;
                end
            end
            ST_SAMPLE: begin
                if (phase_end) begin
                    state_d = ST_CONVERT;
                    tmr_d = conv_len - 12'h001;
                end
            end
            ST_CONVERT: begin
                if (phase_end) begin
                    state_d = ST_XFER;
                    tmr_d = `ADC_XFER_TCL - 12'h001;
                end
            end
            ST_XFER: begin
                if (phase_end) begin
                    state_d = ST_CALC;
                    tmr_d = calc_len - 12'h001;
                end
            end
            ST_CALC: begin
                if (phase_end) begin
                    state_d = buf_full_q ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (result_read_in) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            tmr_q <= 12'h000;
        end else begin
            state_q <= state_d;
            tmr_q <= tmr_d;
        end
    end

    // ----------------------------------------
    // Run control and channel choice
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            run_q <= 1'b0;
            scan_q <= 4'h0;
        end else if (start_in && !run_q) begin
            run_q <= 1'b1;
            scan_q <= channel_in;
        end else if (stop_in) begin
            run_q <= 1'b0;
        end else if (state_q == ST_SAMPLE && state_d == ST_CONVERT &&
                !inj_act_q) begin
            if (last_conv) begin
                run_q <= 1'b0;
            end
            if (mode_in[1]) begin
                // Scan counts down, wrapping to the top channel
                scan_q <= (scan_q == 4'h0) ? channel_in
                    : scan_q - 4'h1;
            end
        end
    end

    // ----------------------------------------
    // Injection
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            inj_pend_q <= 1'b0;
            inj_act_q <= 1'b0;
        end else begin
            if (state_q == ST_IDLE && state_d == ST_SAMPLE) begin
                inj_act_q <= inj_pend_q;
            end else if (state_q == ST_CALC && phase_end) begin
                inj_act_q <= 1'b0;
            end
            if (inject_req_in && run_q && is_cont) begin
                inj_pend_q <= 1'b1;
            end else if (state_q == ST_IDLE && state_d == ST_SAMPLE) begin
                inj_pend_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Core drive
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            core_channel_out <= 4'h0;
            core_sample_out <= 1'b0;
            core_convert_out <= 1'b0;
            core_calibrate_out <= 1'b0;
            conversion_active_out <= 1'b0;
        end else begin
            if (state_q == ST_IDLE && state_d == ST_SAMPLE) begin
                core_channel_out <= inj_pend_q ? inject_channel_in
                    : (mode_in[1] ? scan_q : channel_in);
            end
            core_sample_out <= (state_d == ST_SAMPLE);
            core_convert_out <= (state_d == ST_CONVERT);
            core_calibrate_out <= (state_d == ST_CALC);
            conversion_active_out <= (state_d != ST_IDLE);
        end
    end

    // ----------------------------------------
    // Results, buffer and overrun
    // ----------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            result_value_field_out <= 10'h000;
            result_channel_out <= 4'h0;
            injection_result_reg_out <= 10'h000;
            unread_q <= 1'b0;
            buf_full_q <= 1'b0;
            buf_q <= 10'h000;
            buf_ch_q <= 4'h0;
            overrun_irq_out <= 1'b0;
            complete_req_out <= 1'b0;
            inject_done_out <= 1'b0;
        end else begin
            overrun_irq_out <= 1'b0;
            complete_req_out <= xfer_go;
            inject_done_out <= xfer_go && inj_act_q;
            if (xfer_go && inj_act_q) begin
                injection_result_reg_out <= core_result_in;
            end
            if (xfer_go && !inj_act_q && wait_for_read_enable_in &&
                    is_cont && unread_q && !result_read_in) begin
                buf_q <= core_result_in;
                buf_ch_q <= core_channel_out;
                buf_full_q <= 1'b1;
            end else if (xfer_go && !inj_act_q) begin
                result_value_field_out <= core_result_in;
                result_channel_out <= core_channel_out;
                unread_q <= 1'b1; // Set wins over a read in this cycle
                if (unread_q && !result_read_in && !overrun_protect_in) begin
                    overrun_irq_out <= 1'b1;
                end
            end else if (result_read_in && buf_full_q) begin
                result_value_field_out <= buf_q;
                result_channel_out <= buf_ch_q;
                buf_full_q <= 1'b0;
            end else if (result_read_in) begin
                unread_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Post-reset calibration and busy flag
    // ----------------------------------------
    logic [CAL_W-1:0] cal_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cal_q <= CAL_W'(CAL_CYC);
            converter_busy_flag_out <= 1'b1;
        end else begin
            // Time spent converting is not counted
            if (cal_q != '0 && state_q == ST_IDLE) begin
                cal_q <= cal_q - CAL_W'(1);
            end
            converter_busy_flag_out <= (cal_q > CAL_W'(1)) ||
                (cal_q == CAL_W'(1) && state_q != ST_IDLE);
        end
    end

    // ----------------------------------------
    // Digital read-back of channel pins
    // ----------------------------------------
    logic [15:0] pin_s1_q, pin_s2_q, pin_s3_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pin_s1_q <= 16'h0000;
            pin_s2_q <= 16'h0000;
            pin_s3_q <= 16'h0000;
            digital_pins_out <= 16'h0000;
        end else begin
            pin_s1_q <= analog_pins_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            digital_pins_out <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) |
                (digital_pins_out & (pin_s2_q ^ pin_s3_q));
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    xfer_len_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(state_q == ST_XFER) |-> tmr_q == 12'h003)
        else $error("transfer phase not four base phases");

    sample_len_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(state_q == ST_SAMPLE) |->
        tmr_q == smp_len - 12'h001 && div_q == 8'h00)
        else $error("sample phase not full length");

    calc_len_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(state_q == ST_CALC) |-> tmr_q == calc_len - 12'h001)
        else $error("calibration cycle length wrong");

    overrun_irq_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (xfer_go && !inj_act_q && unread_q && !result_read_in &&
        !overrun_protect_in && !buf_full_q && !(wait_for_read_enable_in &&
        is_cont)) |=> overrun_irq_out)
        else $error("overrun not signalled");

    protect_hold_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_q == ST_IDLE && overrun_protect_in && unread_q)
        |=> state_q != ST_SAMPLE)
        else $error("conversion started over unread result");

    single_stop_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_q == ST_SAMPLE && state_d == ST_CONVERT && !inj_act_q &&
        mode_in == MODE_SINGLE && !start_in) |=> !run_q)
        else $error("single mode did not stop");

    inject_keep_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (xfer_go && inj_act_q && !result_read_in) |=>
        $stable(result_value_field_out) && inject_done_out)
        else $error("injection touched normal result");

    hold_read_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (state_q == ST_HOLD && result_read_in && !xfer_go) |=>
        result_value_field_out == $past(buf_q) && state_q == ST_IDLE)
        else $error("buffered result not released on read");

    complete_req_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        $rose(state_q == ST_XFER) |-> complete_req_out ##1 !complete_req_out)
        else $error("completion request not a single pulse");

    busy_cal_a: assert property (
        @(posedge ref_clk_in) disable iff (rst_in)
        (cal_q > CAL_W'(2)) |=> converter_busy_flag_out)
        else $error("busy dropped during calibration");

endmodule : adc_sequencer_control

// File: inc/adc_seq_params.svh
// Timing, code and reset constants for the conversion sequencer.
// Assumes a single 100 MHz system clock.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ----------------------------------------
// Clock and base phase
// ----------------------------------------
`define ADC_CLK_NS 10
`define ADC_TCL_NS 20
`define ADC_TCL_CYC ((`ADC_TCL_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

// ----------------------------------------
// Conversion clock in base phases
// ----------------------------------------
`define ADC_CTC_00_TCL 7'h18
`define ADC_CTC_10_TCL 7'h60
`define ADC_CTC_11_TCL 7'h30

// ----------------------------------------
// Sequence lengths
// ----------------------------------------
`define ADC_CONV_TCC 12'h00e
`define ADC_XFER_TCL 12'h004
`define ADC_CALC_TCC_SHIFT 2

// ----------------------------------------
// Post-reset calibration
// ----------------------------------------
`define ADC_CAL_NS 1600000
`define ADC_CAL_CYC ((`ADC_CAL_NS + `ADC_CLK_NS - 1) / `ADC_CLK_NS)

`endif

// File: inc/adc_seq_pkg.sv
// Types for the conversion sequencer.
// Assumes nothing of its surroundings.
package adc_seq_pkg;

    // ----------------------------------------
    // Sequencer states and modes
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT,
        ST_XFER,
        ST_CALC,
        ST_HOLD
    } seq_state_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_CONT = 2'h1,
        MODE_SCAN = 2'h2,
        MODE_SCAN_CONT = 2'h3
    } conv_mode_t;

endpackage : adc_seq_pkg

// File: bench/adc_core_model.sv
// Behavioural analog mux and conversion core; no sample-hold is modelled.
// Assumes the sequencer samples the result late in its convert phase.
`timescale 1ns/1ps

module adc_core_model (
    input wire logic ref_clk_in,
    input wire logic [3:0] core_channel_in,
    input wire logic core_convert_in,
    output logic [9:0] core_result_out
);
    logic [9:0] junk_q = 10'h155;

    // ----
    // Result only valid while converting
    // ----
    always @(posedge ref_clk_in) begin
        junk_q <= ~junk_q;
    end

    assign core_result_out = core_convert_in ?
        {core_channel_in, 2'h1, core_channel_in} : junk_q;

endmodule : adc_core_model

// File: bench/tb_adc_sequencer_control.sv
// Self-checking bench for the conversion sequencer.
// Assumes adc_core_model stands in for the analog core.
`timescale 1ns/1ps

module tb_adc_sequencer_control;
    import adc_seq_pkg::*;
    localparam int CAL = 200;
    logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, stop = 1'b0;
    logic [1:0] mode = 2'h0, ctc = 2'h0, stc = 2'h0;
    logic [3:0] chan = 4'h0, inj_ch = 4'h0, core_ch, res_ch;
    logic wfr = 1'b0, prot = 1'b0, inj = 1'b0, rd = 1'b0;
    logic [9:0] core_res, res, inj_res;
    logic [15:0] pins_in = 16'h0000, pins_out;
    logic samp, conv, cal, busy, active, irq, done, inj_done;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    int n_done = 0, n_irq = 0, t_done = 0, t_inj = -1;
    int n_cal = 0, n_smp = 0;

    adc_sequencer_control #(.CAL_CYC(CAL)) dut (
        .ref_clk_in(ref_clk), .rst_in(rst), .start_in(start),
        .stop_in(stop), .mode_in(mode), .channel_in(chan),
        .wait_for_read_enable_in(wfr), .overrun_protect_in(prot),
        .conversion_clock_select_in(ctc), .sample_clock_select_in(stc),
        .inject_req_in(inj), .inject_channel_in(inj_ch),
        .result_read_in(rd), .core_result_in(core_res),
        .analog_pins_in(pins_in), .core_channel_out(core_ch),
        .core_sample_out(samp), .core_convert_out(conv),
        .core_calibrate_out(cal), .result_value_field_out(res),
        .result_channel_out(res_ch), .injection_result_reg_out(inj_res),
        .converter_busy_flag_out(busy), .conversion_active_out(active),
        .overrun_irq_out(irq), .complete_req_out(done),
        .inject_done_out(inj_done), .digital_pins_out(pins_out));

    adc_core_model core (.ref_clk_in(ref_clk), .core_channel_in(core_ch),
        .core_convert_in(conv), .core_result_out(core_res));

    // ----
    // Clock, monitors and timeout
    // ----
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc++;
        if (done === 1'b1) begin
            n_done++;
            t_done = cyc;
        end
        if (inj_done === 1'b1) t_inj = cyc;
        if (irq === 1'b1) n_irq++;
        if (cal === 1'b1) n_cal++;
        if (samp === 1'b1) n_smp++;
        if (cyc == 80000) begin
            num_errors++;
            final_report();
        end
    end

    // ----
    // Helpers
    // ----
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic tick;
        @(posedge ref_clk);
        #1;
    endtask : tick

    function automatic logic [9:0] ev(input logic [3:0] c);
        return {c, 2'h1, c};
    endfunction : ev

    function automatic int tcc(input logic [1:0] c);
        return (c == 2'h2) ? 96 : (c == 2'h3) ? 48 : 24;
    endfunction : tcc

    function automatic int per(input logic [1:0] c, input logic [1:0] s);
        int t;
        t = (c == 2'h2) ? 96 : (c == 2'h3) ? 48 : 24;
        return 2 * (14 * t + 2 * (t << s) + 4) + 8 * t + 1;
    endfunction : per

    task automatic go(input logic [1:0] m, input logic [3:0] c);
        mode = m;
        chan = c;
        start = 1'b1;
        tick;
        start = 1'b0;
    endtask : go

    task automatic read_res;
        rd = 1'b1;
        tick;
        rd = 1'b0;
    endtask : read_res

    task automatic wait_done(input int lim);
        int n0;
        n0 = n_done;
        repeat (lim) begin
            tick;
            if (n_done != n0) break;
        end
        check(16'(n_done != n0), 16'h0001);
    endtask : wait_done

    task automatic stop_all;
        stop = 1'b1;
        tick;
        stop = 1'b0;
        repeat (9000) begin
            if (active === 1'b0) break;
            tick;
        end
        check(active, 16'h0000);
    endtask : stop_all

    // ----
    // Scenarios
    // ----
    task automatic t_reset(input bit conv_too);
        int n;
        rst = 1'b1;
        repeat (16) tick;
        rst = 1'b0;
        check(busy, 16'h0001);
        if (conv_too) go(MODE_SINGLE, 4'h9);
        n = 0;
        while (busy === 1'b1 && n < 5000) begin
            tick;
            n++;
        end
        if (conv_too) begin
            check(16'(n >= CAL + 776 && n <= CAL + 1000), 16'h0001);
            check(res_ch, 16'h0009);
            check(res, ev(4'h9));
            repeat (1100) tick;
            check(16'(n_done), 16'h0001);
        end else begin
            check(16'(n >= CAL - 2 && n <= CAL + 3), 16'h0001);
        end
    endtask : t_reset

    task automatic t_timing(input logic [1:0] c, input logic [1:0] s);
        int t1, n1, c1, s1;
        ctc = c;
        stc = s;
        read_res;
        n1 = n_irq;
        go(MODE_CONT, 4'h6);
        wait_done(9000);
        t1 = t_done;
        c1 = n_cal;
        s1 = n_smp;
        check(res_ch, 16'h0006);
        check(res, ev(4'h6));
        wait_done(9000);
        check(16'(n_cal - c1), 16'(8 * tcc(c)));
        check(16'(n_smp - s1), 16'(4 * (tcc(c) << s)));
        repeat (2) tick;
        check(16'(t_done - t1), 16'(per(c, s)));
        check(16'(n_irq - n1), 16'h0001);
        stop_all;
    endtask : t_timing

    task automatic t_protect;
        int n0;
        ctc = 2'h0;
        stc = 2'h0;
        prot = 1'b1;
        read_res;
        go(MODE_CONT, 4'h3);
        wait_done(2000);
        n0 = n_done;
        repeat (2500) tick;
        check(16'(n_done - n0), 16'h0000);
        read_res;
        wait_done(2000);
        stop_all;
        prot = 1'b0;
    endtask : t_protect

    task automatic t_wfr;
        wfr = 1'b1;
        read_res;
        go(MODE_SCAN_CONT, 4'h2);
        wait_done(2000);
        check(res_ch, 16'h0002);
        repeat (3000) tick;
        check(res_ch, 16'h0002);
        check(res, ev(4'h2));
        read_res;
        tick;
        check(res_ch, 16'h0001);
        check(res, ev(4'h1));
        read_res;
        wait_done(2000);
        check(res_ch, 16'h0000);
        read_res;
        wait_done(2000);
        check(res_ch, 16'h0002);
        stop_all;
        wfr = 1'b0;
    endtask : t_wfr

    task automatic t_scan;
        int k;
        go(MODE_SCAN, 4'h3);
        for (k = 3; k >= 0; k--) begin
            wait_done(2000);
            check(res_ch, 16'(k));
            check(res, ev(4'(k)));
            read_res;
        end
        repeat (1200) tick;
        check(active, 16'h0000);
    endtask : t_scan

    task automatic t_inject;
        go(MODE_CONT, 4'h7);
        wait_done(2000);
        inj_ch = 4'hc;
        inj = 1'b1;
        tick;
        inj = 1'b0;
        wait_done(2000);
        check(16'(t_inj == t_done), 16'h0001);
        check(inj_res, ev(4'hc));
        check(res_ch, 16'h0007);
        wait_done(2000);
        check(res_ch, 16'h0007);
        check(res, ev(4'h7));
        stop_all;
    endtask : t_inject

    // ----
    // Main sequence; conversion clock select code 01 is never programmed
    // ----
    initial begin
        t_reset(1'b0);
        t_reset(1'b1);
        pins_in = 16'ha5c3;
        repeat (8) tick;
        check(pins_out, 16'ha5c3);
        pins_in = 16'h5a3c;
        repeat (8) tick;
        check(pins_out, 16'h5a3c);
        t_timing(2'h0, 2'h0);
        t_timing(2'h2, 2'h1);
        t_timing(2'h3, 2'h2);
        t_timing(2'h0, 2'h3);
        t_protect;
        t_wfr;
        t_scan;
        t_inject;
        final_report();
    end

endmodule : tb_adc_sequencer_control
